// *** core/txpf_regs.svh ***
// Register offsets, field positions, reset values and timing figures
// for the transmit packet framer. Included by the framer package only.
`ifndef TXPF_REGS_SVH
`define TXPF_REGS_SVH

`define TXPF_A_LINK 6'h0E
`define TXPF_A_PAIR 6'h13
`define TXPF_A_PKT 6'h18
`define TXPF_A_WHT 6'h19
`define TXPF_A_DTAG 6'h1A
`define TXPF_A_HOP 6'h1F
`define TXPF_A_LSD 6'h25
`define TXPF_A_USER 6'h28
`define TXPF_A_LAUNCH 6'h30
`define TXPF_A_MODE 6'h31
`define TXPF_A_USER_LAST 6'h2F

`define TXPF_B_LAUNCH 7
`define TXPF_B_DTAG 5
`define TXPF_B_CRC_EN 1
`define TXPF_B_CRC_W 2
`define TXPF_B_WHT_EN 7
`define TXPF_B_LSD_EN 0

`define TXPF_RST_PKT 8'h11
`define TXPF_RST_WHT 8'h01

`define TXPF_PRE_ZERO 8'h55
`define TXPF_PRE_ONE 8'hAA
`define TXPF_CRC8_POLY 8'h07
`define TXPF_CRC8_SEED 8'hFF
`define TXPF_CRC16_POLY 16'h1021
`define TXPF_CRC16_SEED 16'hFFFF
`define TXPF_DTAG_LEN 4'h3
`define TXPF_USER_MAX 4'h8

`define TXPF_IDLE_MS 2
`define TXPF_CLK_KHZ 20000
`define TXPF_IDLE_CYCLES (`TXPF_IDLE_MS * `TXPF_CLK_KHZ)
`define TXPF_BIT_DIV 80

`endif

// *** core/txpf_pkg.sv ***
// Types shared by the transmit packet framer and its bench.
// Assumes txpf_regs.svh is on the include path.
`default_nettype none

package txpf_pkg;
  `include "txpf_regs.svh"

  typedef enum logic [0:0] {PW_LIGHT = 1'b0, PW_DEEP = 1'b1} txpf_pwr_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PRE = 3'b001,
    TX_ADDR = 3'b010,
    TX_CTRL = 3'b011,
    TX_PAY = 3'b100,
    TX_CRC = 3'b101,
    TX_GAP = 3'b110
  } txpf_tx_t;

  typedef enum logic [1:0] {
    MD_HOST = 2'b00,
    MD_KEY = 2'b01,
    MD_PERIOD = 2'b10,
    MD_PAIR = 2'b11
  } txpf_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic page;
  } txpf_bus_t;

  typedef struct packed {
    logic data;
    logic stb;
    logic busy;
    logic [1:0] chan;
  } txpf_air_t;

  typedef struct packed {
    logic [63:0][7:0] regs;
    logic [7:0] rdata;
    txpf_pwr_t pwr;
    logic [31:0] idle;
    txpf_tx_t tx;
    logic [15:0] div;
    logic [3:0] bit_n;
    logic [3:0] byte_n;
    logic [1:0] seq;
    logic [15:0] crc;
    logic [6:0] lfsr;
    logic [1:0] chan;
    logic [3:0] rep;
    logic [3:0] pay_cnt;
    logic [5:0] pay_nxt;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] low_s;
    logic [1:0][7:0] key_s;
    txpf_air_t air;
  } txpf_st_t;
endpackage : txpf_pkg

`default_nettype wire

// *** core/txpf_framer.sv ***
// Transmit packet framer: register file, sleep control, packet
// serializer with CRC, whitening and frequency hop sequencing.
// Assumes a 20 MHz sys_clk_i; serial bus pins and key pins are async.
`default_nettype none

module txpf_framer
  import txpf_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `TXPF_IDLE_CYCLES,
  parameter int unsigned BIT_DIV = `TXPF_BIT_DIV
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire txpf_pkg::txpf_bus_t bus_i,
  output logic [7:0] rd_data_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] key_n_i,
  input wire logic low_supply_i,
  output txpf_pkg::txpf_air_t air_o,
  output logic deep_sleep_o
);
  import txpf_pkg::*;

  function automatic logic [63:0][7:0] cfg_default();
    logic [63:0][7:0] r;
    r = '0;
    r[`TXPF_A_PKT] = `TXPF_RST_PKT;
    r[`TXPF_A_WHT] = `TXPF_RST_WHT;
    return r;
  endfunction : cfg_default

  function automatic txpf_st_t st_reset();
    txpf_st_t t;
    t = '0;
    t.regs = cfg_default();
    t.scl_s = 3'h7;
    t.sda_s = 3'h7;
    t.key_s = 16'hFFFF;
    return t;
  endfunction : st_reset

  // One serial CRC step; the narrow form lives in the low byte
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic d,
                                           input logic w);
    logic fb;
    logic [7:0] lo;
    fb = w ? (c[15] ^ d) : (c[7] ^ d);
    lo = {c[6:0], 1'b0} ^ (fb ? `TXPF_CRC8_POLY : 8'h00);
    if (w)
    begin
      return {c[14:0], 1'b0} ^ (fb ? `TXPF_CRC16_POLY : 16'h0000);
    end
    return {8'h00, lo};
  endfunction : crc_step

  localparam txpf_st_t ST_RST = st_reset();
  localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);
  localparam logic [31:0] IDLE_LAST = 32'(IDLE_CYCLES - 1);

  txpf_st_t s;
  txpf_st_t n;

  logic [7:0] pkt_r;
  logic [2:0] alen;
  logic dt;
  txpf_mode_t mode;
  logic [5:0] abase;
  logic [7:0] abyte;
  logic fa;
  logic lsd;
  logic [7:0] key_byte;
  logic [3:0] pidx;
  logic [7:0] pbyte;
  logic [3:0] plen;
  logic [8:0] ctrl9;
  logic crc_on;
  logic crc_w;
  logic [2:0] bsel;
  logic [7:0] pre;
  logic raw;
  logic wh;
  logic tick;
  logic act;
  logic fall;
  logic last_ch;
  logic last_rep;
  logic hop2;
  logic done;
  logic wr_ok;
  logic [5:0] wa;

  assign pkt_r = s.regs[`TXPF_A_PKT];
  assign alen = pkt_r[7] ? 3'd5 : (pkt_r[6] ? 3'd4 : 3'd3);
  assign dt = pkt_r[`TXPF_B_DTAG];
  assign mode = txpf_mode_t'(s.regs[`TXPF_A_MODE][1:0]);
  assign abase = (mode == MD_PAIR) ? `TXPF_A_PAIR : `TXPF_A_LINK;
  // Highest included address byte goes first on air
  assign abyte = s.regs[abase + 6'(alen) - 6'd1 - 6'(s.byte_n)];
  assign fa = s.regs[abase + 6'(alen) - 6'd1][7];
  assign lsd = s.regs[`TXPF_A_LSD][`TXPF_B_LSD_EN] & s.low_s[1];
  assign key_byte = {s.regs[`TXPF_A_LSD][`TXPF_B_LSD_EN] ? s.low_s[1]
                     : s.key_s[1][7], s.key_s[1][6:0]};
  assign pidx = s.byte_n - (dt ? `TXPF_DTAG_LEN : 4'h0);
  assign pbyte = (dt && s.byte_n < `TXPF_DTAG_LEN)
                 ? s.regs[`TXPF_A_DTAG + 6'(s.byte_n)]
                 : (mode == MD_HOST) ? s.regs[`TXPF_A_USER + 6'(pidx)]
                 : (mode == MD_KEY) ? key_byte
                 : (mode == MD_PERIOD) ? {lsd, 7'h00}
                 : s.regs[`TXPF_A_LINK + 6'(alen) - 6'd1 - 6'(pidx)];
  assign plen = (dt ? `TXPF_DTAG_LEN : 4'h0)
                + ((mode == MD_HOST) ? s.pay_cnt
                : (mode == MD_PAIR) ? 4'(alen) : 4'h1);
  assign ctrl9 = {2'b00, plen, s.seq, 1'b1};
  assign crc_on = pkt_r[`TXPF_B_CRC_EN];
  assign crc_w = pkt_r[`TXPF_B_CRC_W];
  assign bsel = 3'(3'd7 - s.bit_n[2:0]);
  assign pre = fa ? `TXPF_PRE_ONE : `TXPF_PRE_ZERO;
  assign raw = (s.tx == TX_PRE) ? pre[bsel]
               : (s.tx == TX_ADDR) ? abyte[bsel]
               : (s.tx == TX_CTRL) ? ctrl9[4'(4'd8 - s.bit_n)]
               : (s.tx == TX_PAY) ? pbyte[bsel]
               : crc_w ? s.crc[{~s.byte_n[0], bsel}]
               : s.crc[{1'b0, bsel}];
  assign wh = s.regs[`TXPF_A_WHT][`TXPF_B_WHT_EN]
              && (s.tx == TX_PAY || s.tx == TX_CRC);
  assign tick = (s.tx != TX_IDLE) && (s.div == DIV_LAST);
  // Edges are taken from the second and third stages only
  assign act = (s.scl_s[1] ^ s.scl_s[2]) | (s.sda_s[1] ^ s.sda_s[2]);
  assign fall = (s.scl_s[2] & ~s.scl_s[1]) | (s.sda_s[2] & ~s.sda_s[1]);
  assign last_ch = s.chan == s.regs[`TXPF_A_HOP][5:4];
  assign last_rep = s.rep == s.regs[`TXPF_A_HOP][3:0];
  assign hop2 = s.regs[`TXPF_A_HOP][7:6] != 2'b00;
  assign done = last_ch && last_rep;
  assign wa = bus_i.addr[5:0];
  // Deep sleep keeps the bus read path and the pin wake edge detect awake, but writes are dropped there
  assign wr_ok = bus_i.wr && (s.pwr == PW_LIGHT) && (bus_i.addr[7:6] == 2'b00);

  always_comb
  begin
    n = s;
    n.rdata = 8'h00;
    n.air.stb = 1'b0;
    n.scl_s = {s.scl_s[1:0], scl_i};
    n.sda_s = {s.sda_s[1:0], sda_i};
    n.low_s = {s.low_s[0], low_supply_i};
    n.key_s = {s.key_s[0], key_n_i};

    if (bus_i.rd && bus_i.addr[7:6] == 2'b00)
    begin
      if (wa == `TXPF_A_LAUNCH)
      begin
        n.rdata = {s.tx != TX_IDLE, 3'b000, s.pay_cnt};
      end
      else if (wa == `TXPF_A_MODE)
      begin
        n.rdata = {s.pwr == PW_DEEP, s.tx != TX_IDLE, s.seq, 2'b00,
                   s.regs[`TXPF_A_MODE][1:0]};
      end
      else
      begin
        n.rdata = s.regs[wa];
      end
    end

    if (wr_ok)
    begin
      if (wa == `TXPF_A_LAUNCH)
      begin
        if (bus_i.wdata[`TXPF_B_LAUNCH] && s.tx == TX_IDLE)
        begin
          n.regs[wa][`TXPF_B_LAUNCH] = 1'b1;
          n.tx = TX_PRE;
          n.div = 16'h0000;
          n.bit_n = 4'h0;
          n.byte_n = 4'h0;
          n.chan = 2'b00;
          n.rep = 4'h0;
          n.crc = crc_w ? `TXPF_CRC16_SEED : {8'h00, `TXPF_CRC8_SEED};
          n.lfsr = s.regs[`TXPF_A_WHT][6:0];
        end
      end
      else
      begin
        n.regs[wa] = bus_i.wdata;
      end
      // Length counts only a page write run starting at the first byte
      if (bus_i.page && wa == `TXPF_A_USER)
      begin
        n.pay_cnt = 4'h1;
        n.pay_nxt = `TXPF_A_USER + 6'h01;
      end
      else if (bus_i.page && wa == s.pay_nxt && s.pay_cnt != 4'h0
               && s.pay_cnt < `TXPF_USER_MAX)
      begin
        n.pay_cnt = s.pay_cnt + 4'h1;
        n.pay_nxt = s.pay_nxt + 6'h01;
      end
    end

    if (s.tx != TX_IDLE)
    begin
      n.div = tick ? 16'h0000 : s.div + 16'h0001;
    end
    if (tick)
    begin
      n.air.data = raw ^ (wh & s.lfsr[6]);
      n.air.stb = (s.tx != TX_GAP);
      n.bit_n = s.bit_n + 4'h1;
      if (s.tx == TX_ADDR || s.tx == TX_CTRL || s.tx == TX_PAY)
      begin
        n.crc = crc_step(s.crc, raw, crc_w);
      end
      if (wh)
      begin
        n.lfsr = {s.lfsr[5:0], s.lfsr[6] ^ s.lfsr[3]};
      end
      case (s.tx)
        TX_PRE:
        begin
          if (s.bit_n == 4'h7)
          begin
            n.tx = TX_ADDR;
            n.bit_n = 4'h0;
          end
        end
        TX_ADDR:
        begin
          if (s.bit_n == 4'h7)
          begin
            n.bit_n = 4'h0;
            n.byte_n = s.byte_n + 4'h1;
            if (s.byte_n == 4'(alen) - 4'h1)
            begin
              n.tx = TX_CTRL;
              n.byte_n = 4'h0;
            end
          end
        end
        TX_CTRL:
        begin
          if (s.bit_n == 4'h8)
          begin
            n.bit_n = 4'h0;
            n.tx = (plen != 4'h0) ? TX_PAY : (crc_on ? TX_CRC : TX_GAP);
          end
        end
        TX_PAY:
        begin
          if (s.bit_n == 4'h7)
          begin
            n.bit_n = 4'h0;
            n.byte_n = s.byte_n + 4'h1;
            if (s.byte_n == plen - 4'h1)
            begin
              n.byte_n = 4'h0;
              n.tx = crc_on ? TX_CRC : TX_GAP;
            end
          end
        end
        TX_CRC:
        begin
          if (s.bit_n == 4'h7)
          begin
            n.bit_n = 4'h0;
            n.byte_n = s.byte_n + 4'h1;
            if (s.byte_n == {3'b000, crc_w})
            begin
              n.tx = TX_GAP;
            end
          end
        end
        TX_GAP:
        begin
          n.seq = s.seq + 2'b01;
          n.bit_n = 4'h0;
          n.byte_n = 4'h0;
          n.crc = crc_w ? `TXPF_CRC16_SEED : {8'h00, `TXPF_CRC8_SEED};
          n.lfsr = s.regs[`TXPF_A_WHT][6:0];
          if (done)
          begin
            n.tx = TX_IDLE;
            n.regs[`TXPF_A_LAUNCH][`TXPF_B_LAUNCH] = 1'b0;
          end
          else
          begin
            n.tx = TX_PRE;
            if (hop2)
            begin
              n.rep = last_rep ? 4'h0 : s.rep + 4'h1;
              n.chan = last_rep ? s.chan + 2'b01 : s.chan;
            end
            else
            begin
              n.chan = last_ch ? 2'b00 : s.chan + 2'b01;
              n.rep = last_ch ? s.rep + 4'h1 : s.rep;
            end
          end
        end
        default:
        begin
          n.tx = TX_IDLE;
        end
      endcase
    end
    n.air.busy = (n.tx != TX_IDLE);
    n.air.chan = n.chan;

    case (s.pwr)
      PW_LIGHT:
      begin
        if (act || s.tx != TX_IDLE || bus_i.wr || bus_i.rd)
        begin
          n.idle = 32'h0;
        end
        else if (s.idle >= IDLE_LAST)
        begin
          n.pwr = PW_DEEP;
          n.idle = 32'h0;
        end
        else
        begin
          n.idle = s.idle + 32'h1;
        end
      end
      PW_DEEP:
      begin
        if (fall)
        begin
          // Sequence tag is kept: it lives outside the reload
          n.pwr = PW_LIGHT;
          n.regs = cfg_default();
          n.pay_cnt = 4'h0;
        end
      end
      default:
      begin
        n.pwr = PW_LIGHT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s <= ST_RST;
    end
    else
    begin
      s <= n;
    end
  end

  assign rd_data_o = s.rdata;
  assign air_o = s.air;
  assign deep_sleep_o = (s.pwr == PW_DEEP);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  idle_to_deep_a: assert property (
    s.pwr == PW_LIGHT && s.idle == IDLE_LAST && !act && s.tx == TX_IDLE
    && !bus_i.wr && !bus_i.rd |=> deep_sleep_o)
    else $error("idle timer expiry did not enter deep sleep");
  toggle_clear_a: assert property (
    s.pwr == PW_LIGHT && act |=> s.idle == 32'h0 && !deep_sleep_o)
    else $error("line toggle did not restart idle timer");
  wake_reload_a: assert property (
    s.pwr == PW_DEEP && fall |=> !deep_sleep_o
    && s.regs[`TXPF_A_PKT] == `TXPF_RST_PKT && s.seq == $past(s.seq))
    else $error("wake did not reload config or kept no tag");
  pre_phase_a: assert property (
    tick && s.tx == TX_PRE && s.bit_n == 4'h0 |=> air_o.data == $past(fa))
    else $error("preamble phase does not follow address bit");
  noreply_bit_a: assert property (
    tick && s.tx == TX_CTRL && s.bit_n == 4'h8 && !wh |=> air_o.data)
    else $error("no-reply flag sent as zero");
  seq_step_a: assert property (
    tick && s.tx == TX_GAP |=> s.seq == $past(s.seq) + 2'b01)
    else $error("sequence tag did not step after packet");
  single_wr_a: assert property (
    bus_i.wr && !bus_i.page |=> s.pay_cnt == $past(s.pay_cnt)
    || $past(s.pwr) == PW_DEEP)
    else $error("single write moved payload counter");
  launch_go_a: assert property (
    wr_ok && wa == `TXPF_A_LAUNCH && bus_i.wdata[`TXPF_B_LAUNCH]
    && s.tx == TX_IDLE |=> air_o.busy ##0 s.tx == TX_PRE)
    else $error("launch bit did not start a packet");

  pkt_done_c: cover property (tick && s.tx == TX_GAP && done);
  crc16_c: cover property (tick && s.tx == TX_CRC && crc_w);
  deep_entry_c: cover property (s.pwr == PW_LIGHT ##1 s.pwr == PW_DEEP);
  hop_two_c: cover property (tick && s.tx == TX_GAP && hop2 && last_rep);
endmodule : txpf_framer

`default_nettype wire

// *** tb/txpf_host_model.sv ***
// Host side of the two-wire bus, reduced to pin levels.
// Assumes the bench pulses wake_i or burst_i for a short while.
`default_nettype none

module txpf_host_model #(
  parameter int HOLD_NS = 1000
)
(
  input wire logic wake_i,
  input wire logic burst_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both lines rest at the pull-up level between transfers
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Pin moves stay clear of the sampling clock edges
  always @(posedge wake_i)
  begin
    #10 sda_o = 1'b0;
    #(HOLD_NS) sda_o = 1'b1;
  end
  // Clock toggles only inside a burst, so the idle timer sees edges
  always @(posedge burst_i)
  begin
    #10;
    repeat (4)
    begin
      #200 scl_o = 1'b0;
      #200 scl_o = 1'b1;
    end
  end
endmodule : txpf_host_model

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the framer: register bus, air bits, sleep.
// Assumes txpf_pkg and txpf_host_model are compiled first.
`default_nettype none

module testbench;
  import txpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  txpf_bus_t bus = '0;
  logic [7:0] rd_data;
  logic [7:0] key_n = 8'hFF;
  logic low = 1'b0;
  logic wake = 1'b0;
  logic burst = 1'b0;
  logic scl;
  logic sda;
  txpf_air_t air;
  logic deep;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] adr [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hC5};
  logic [7:0] pa [5] = '{8'h9A, 8'hAB, 8'hBC, 8'hCD, 8'hDE};
  logic [7:0] pl [$];
  logic bitq [$];
  int alen = 3;
  bit crc_en = 0;
  bit crc16 = 0;
  bit wht = 0;
  bit pair = 0;
  logic [6:0] seed = 7'h01;
  logic [1:0] sq = 2'h0;
  logic [7:0] d;

  txpf_framer #(
    .IDLE_CYCLES(40),
    .BIT_DIV(4)
  ) dut (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .bus_i(bus),
    .rd_data_o(rd_data),
    .scl_i(scl),
    .sda_i(sda),
    .key_n_i(key_n),
    .low_supply_i(low),
    .air_o(air),
    .deep_sleep_o(deep)
  );
  txpf_host_model #(.HOLD_NS(1000)) host (.wake_i(wake), .burst_i(burst),
    .scl_o(scl), .sda_o(sda));

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic print_verdict();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic p);
    @(posedge sys_clk_i);
    bus.addr <= a;
    bus.wdata <= v;
    bus.page <= p;
    bus.wr <= 1'b1;
    @(posedge sys_clk_i);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk_i);
    bus.rd <= 1'b0;
    @(negedge sys_clk_i);
    v = rd_data;
  endtask : rd

  function automatic void put(ref logic q [$], input logic [15:0] v,
                              input int n);
    for (int k = n - 1; k >= 0; k--)
      q.push_back(v[k]);
  endfunction : put

  // Expected bits of one packet, CRC taken before whitening
  function automatic void build();
    logic b [$];
    logic [15:0] c;
    logic [6:0] lf;
    logic fb;
    int nb;
    c = 16'hFFFF;
    for (int i = alen - 1; i >= 0; i--)
      put(b, pair ? pa[i] : adr[i], 8);
    put(b, {6'(pl.size()), sq, 1'b1}, 9);
    nb = b.size();
    foreach (pl[i])
      put(b, pl[i], 8);
    foreach (b[i])
    begin
      fb = b[i] ^ (crc16 ? c[15] : c[7]);
      c = (c << 1) ^ (fb ? (crc16 ? 16'h1021 : 16'h0007) : 16'h0000);
    end
    if (crc_en)
      put(b, crc16 ? c : {8'h00, c[7:0]}, crc16 ? 16 : 8);
    lf = seed;
    for (int i = nb; i < b.size() && wht; i++)
    begin
      b[i] = b[i] ^ lf[6];
      lf = {lf[5:0], lf[6] ^ lf[3]};
    end
    fb = pair ? pa[alen - 1][7] : adr[alen - 1][7];
    put(bitq, fb ? 16'h00AA : 16'h0055, 8);
    foreach (b[i])
      bitq.push_back(b[i]);
    sq++;
  endfunction : build

  task automatic run_tx(input logic [7:0] h);
    logic [1:0] ch [$];
    logic [1:0] got [$];
    int n, t, pb, bad, rs, nch;
    rs = int'(h[3:0]) + 1;
    nch = int'(h[5:4]) + 1;
    bitq.delete();
    n = 0;
    bad = 0;
    for (int r = 0; r < rs * nch; r++)
    begin
      ch.push_back(2'(h[7:6] == 2'h0 ? r % nch : r / rs));
      build();
    end
    pb = bitq.size() / (rs * nch);
    wr(8'h1F, h, 1'b0);
    wr(8'h30, 8'h80, 1'b0);
    @(negedge sys_clk_i);
    for (t = 0; t < 40000 && air.busy === 1'b1; t++)
    begin
      if (air.stb === 1'b1)
      begin
        if (n % pb == 0)
          got.push_back(air.chan);
        if (n >= bitq.size() || air.data !== bitq[n])
          bad++;
        n++;
      end
      @(negedge sys_clk_i);
    end
    chk("air bits wrong", 0, 16'(bad));
    chk("air bit count", 16'(bitq.size()), 16'(n));
    chk("packet count", 16'(ch.size()), 16'(got.size()));
    for (int i = 0; i < ch.size() && i < got.size(); i++)
      chk("hop channel", ch[i], got[i]);
    if (t == 40000)
    begin
      chk("transmit timeout", 0, 1);
      print_verdict();
    end
  endtask : run_tx

  task automatic t_reset();
    rd(8'h18, d);
    chk("packet control reset", 8'h11, d);
    rd(8'h19, d);
    chk("whitening reset", 8'h01, d);
    wr(8'h40, 8'h5A, 1'b0);
    rd(8'h40, d);
    chk("unmapped read", 8'h00, d);
  endtask : t_reset

  task automatic t_base();
    for (int i = 0; i < 5; i++)
      wr(8'h0E + 8'(i), adr[i], 1'b0);
    wr(8'h18, 8'h00, 1'b0);
    wr(8'h28, 8'hA1, 1'b1);
    wr(8'h29, 8'hB2, 1'b1);
    wr(8'h2A, 8'hC3, 1'b0);
    rd(8'h30, d);
    chk("payload count", 8'h02, d);
    pl = '{8'hA1, 8'hB2};
    run_tx(8'h00);
  endtask : t_base

  task automatic t_crc8();
    wr(8'h18, 8'hA2, 1'b0);
    wr(8'h1A, 8'h5A, 1'b0);
    wr(8'h1B, 8'h6B, 1'b0);
    wr(8'h1C, 8'h7C, 1'b0);
    alen = 5;
    crc_en = 1;
    pl = '{8'h5A, 8'h6B, 8'h7C, 8'hA1, 8'hB2};
    run_tx(8'h11);
  endtask : t_crc8

  task automatic t_crc16w();
    wr(8'h18, 8'h46, 1'b0);
    wr(8'h19, 8'hB5, 1'b0);
    alen = 4;
    crc16 = 1;
    wht = 1;
    seed = 7'h35;
    pl.delete();
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h28 + 8'(i), 8'hD0 + 8'(i), 1'b1);
      pl.push_back(8'hD0 + 8'(i));
    end
    rd(8'h30, d);
    chk("payload count", 8'h08, d);
    run_tx(8'h51);
  endtask : t_crc16w

  task automatic t_modes();
    @(posedge sys_clk_i);
    low <= 1'b1;
    wr(8'h25, 8'h01, 1'b0);
    wr(8'h31, 8'h02, 1'b0);
    pl = '{8'h80};
    run_tx(8'h00);
    @(posedge sys_clk_i);
    low <= 1'b0;
    key_n <= 8'hFE;
    wr(8'h31, 8'h01, 1'b0);
    pl = '{8'h7E};
    run_tx(8'h00);
    for (int i = 0; i < 4; i++)
      wr(8'h13 + 8'(i), pa[i], 1'b0);
    wr(8'h31, 8'h03, 1'b0);
    pair = 1;
    pl = '{adr[3], adr[2], adr[1], adr[0]};
    run_tx(8'h00);
    pair = 0;
    wr(8'h31, 8'h00, 1'b0);
  endtask : t_modes

  task automatic t_sleep();
    int t;
    rd(8'h31, d);
    chk("sequence tag", sq, d[5:4]);
    wr(8'h18, 8'h33, 1'b0);
    repeat (30) @(posedge sys_clk_i);
    chk("deep too early", 0, deep);
    burst <= 1'b1;
    repeat (34) @(posedge sys_clk_i);
    burst <= 1'b0;
    repeat (30) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("deep after toggles", 0, deep);
    repeat (20) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("deep after idle", 1, deep);
    @(posedge sys_clk_i);
    wake <= 1'b1;
    for (t = 0; t < 100 && deep !== 1'b0; t++)
      @(negedge sys_clk_i);
    chk("wake from deep", 0, deep);
    if (t == 100)
      print_verdict();
    repeat (25) @(posedge sys_clk_i);
    wake <= 1'b0;
    rd(8'h18, d);
    chk("reload after wake", 8'h11, d);
    rd(8'h31, d);
    chk("sequence tag kept", sq, d[5:4]);
  endtask : t_sleep

  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_base();
    t_crc8();
    t_crc16w();
    t_modes();
    t_sleep();
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
